/* rtl/outchan_defs.svh */
/*
  Register indices, field positions, reset values and bus widths for the
  channel four source and divider block.
  Assumes it is included by its bare name ahead of the modules using it.
*/
`ifndef OUTCHAN_DEFS_SVH
`define OUTCHAN_DEFS_SVH

// Register indices; the byte address is four times the index.
`define IDX_CTRL 6'h25
`define IDX_DIV 6'h26
`define IDX_CFG 6'h27
`define IDX_STAT 6'h28

// Reset values.
`define RST_CTRL 8'h18
`define RST_DIV 8'h02
`define RST_CFG 8'h00

// Field positions (low bit of each two-bit field).
`define F_MUX 6
`define F_SEL 4
`define F_MODE1 2
`define F_MODE2 0

// Configuration bits.
`define CFG_DBL 0
`define CFG_SECOND_SYNTH 1

// Status bits.
`define ST_DIV_ON 2
`define ST_OUT_ON 3
`define ST_CLK 4
`define ST_RSVD 5

// Bus shape.
`define ADDR_W 8
`define DATA_W 32

`endif

/* rtl/outchan_pkg.sv */
/*
  Types shared by the channel four source and divider block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package outchan_pkg;

  typedef enum logic [1:0]
  {
    SRC_PLL = 2'h0,
    SRC_RSVD = 2'h1,
    SRC_PRI = 2'h2,
    SRC_SEC = 2'h3
  } src_sel_t;

  typedef enum logic [1:0]
  {
    DRV_OFF = 2'h0,
    DRV_AC = 2'h1,
    DRV_HCSL = 2'h2,
    DRV_CMOS = 2'h3
  } drv_type_t;

  typedef enum logic [1:0]
  {
    PIN_TRI = 2'h0,
    PIN_LOW = 2'h1,
    PIN_INV = 2'h2,
    PIN_TRUE = 2'h3
  } pin_mode_t;

  typedef enum logic
  {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_t;

  // Analog driver settings handed to the output stage.
  typedef struct packed
  {
    drv_type_t kind;
    logic [4:0] itail_ma;
    logic [7:0] rload_ohm;
    logic rload_open;
  } drv_cfg_t;

  // Pin levels and enables for the two output legs.
  typedef struct packed
  {
    logic p;
    logic p_oe;
    logic n;
    logic n_oe;
  } drv_pins_t;

endpackage

/* rtl/ratio_divider.sv */
/*
  Integer clock divider working on a sampled source level.
  Assumes the source is slower than half the system clock.
*/
`timescale 1ns/1ps

module ratio_divider
  import outchan_pkg::*;
#(
  parameter int DIV_W = 8
)
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Control.
  input wire logic bypass,
  input wire logic [DIV_W-1:0] ratio_code,
  // Clock level in and out.
  input wire logic src_level,
  output logic div_out
);

  logic src_q;
  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] next_cnt;
  logic [DIV_W-1:0] half;

  generate
    if (DIV_W < 1 || DIV_W > 16)
    begin : g_bad
      $error("ratio_divider: DIV_W out of range");
    end
  endgenerate

  // High time is the rounded-up half of code plus one source periods.
  assign half = (ratio_code >> 1) + {{(DIV_W-1){1'b0}}, 1'b1};
  assign next_cnt = (cnt == ratio_code) ? '0 :
    cnt + {{(DIV_W-1){1'b0}}, 1'b1};

  // Edge memory for the source.
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      src_q <= 1'b0;
    else
      src_q <= src_level;
  end

  // Count source rising edges; ratio is code plus one.
  always_ff @(posedge clock)
  begin
    if (!rst_b || bypass || ratio_code == '0)
    begin
      cnt <= '0;
    end
    else if (src_level && !src_q)
    begin
      cnt <= next_cnt;
    end
  end

  // Output follows the source when bypassed or at ratio one.
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      div_out <= 1'b0;
    else if (bypass || ratio_code == '0)
      div_out <= src_level;
    else if (src_level && !src_q)
      div_out <= next_cnt < half;
  end

endmodule

/* rtl/driver_decode.sv */
/*
  Decodes the driver type and the two mode fields into analog settings
  and pin levels for the two output legs.
  Assumes the caller registers the results.
*/
`timescale 1ns/1ps

module driver_decode
  import outchan_pkg::*;
(
  // Fields.
  input wire drv_type_t kind,
  input wire logic [1:0] mode_primary,
  input wire logic [1:0] mode_secondary,
  // Clock level to drive.
  input wire logic clk_level,
  // Results.
  output drv_cfg_t cfg,
  output drv_pins_t pins
);

  // One single-ended leg: level and enable as a pair {level, oe}.
  function automatic logic [1:0] leg(input logic [1:0] m, input logic c);
    case (m)
      PIN_TRI: leg = 2'h0;
      PIN_LOW: leg = 2'h1;
      PIN_INV: leg = {~c, 1'b1};
      PIN_TRUE: leg = {c, 1'b1};
      default: leg = 2'h0;
    endcase
  endfunction

  // Tail current, load and pin behaviour per driver type.
  always_comb
  begin
    cfg.kind = kind;
    cfg.itail_ma = 5'h00;
    cfg.rload_ohm = 8'h00;
    cfg.rload_open = 1'b1;
    pins = '0;
    case (kind)
      DRV_AC, DRV_HCSL:
      begin
        case (mode_primary)
          2'h0: cfg.itail_ma = 5'h04;
          2'h1: cfg.itail_ma = 5'h06;
          2'h2: cfg.itail_ma = 5'h08;
          default: cfg.itail_ma = (kind == DRV_HCSL) ? 5'h10 : 5'h08;
        endcase
        if (kind == DRV_HCSL)
        begin
          cfg.rload_open = (mode_secondary == 2'h0);
          case (mode_secondary)
            2'h1: cfg.rload_ohm = 8'h32;
            2'h2: cfg.rload_ohm = 8'h64;
            2'h3: cfg.rload_ohm = 8'hC8;
            default: cfg.rload_ohm = 8'h00;
          endcase
        end
        {pins.p, pins.p_oe} = {clk_level, 1'b1};
        {pins.n, pins.n_oe} = {~clk_level, 1'b1};
      end
      DRV_CMOS:
      begin
        {pins.p, pins.p_oe} = leg(mode_primary, clk_level);
        {pins.n, pins.n_oe} = leg(mode_secondary, clk_level);
      end
      default:
      begin
        pins = '0;
      end
    endcase
  end

endmodule

/* rtl/output_channel_source_divider.sv */
/*
  Channel four source selection, output divider and driver control, with
  its registers on an Avalon-MM slave that inserts one wait state.
  Assumes the clock inputs of the channel are slow enough to be sampled
  as ordinary synchronous levels by the 50 MHz system clock.
*/
`timescale 1ns/1ps

`include "outchan_defs.svh"

// Behaviour
// - Two-bit mux picks PLL, primary or secondary.
// - Divider used only for PLL sources; bypassed otherwise.
// - Doubler on makes references carry doubled frequency.
// - Driver select: off, AC, HCSL or LVCMOS.
// - Differential tail current from first mode field.
// - Single-ended positive leg from first mode.
module output_channel_source_divider
  import outchan_pkg::*;
#(
  parameter int DIV_W = 8
)
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Avalon-MM slave, byte addressed.
  input wire logic [`ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [`DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [`DATA_W-1:0] readdata,
  output logic waitrequest,
  // Candidate channel clocks, sampled as levels.
  input wire logic pll_clk_in,
  input wire logic second_synth_source_in,
  input wire logic pri_ref_in,
  input wire logic sec_ref_in,
  // Channel clock after mux and divider.
  output logic chan_clk,
  // Output legs.
  output logic out_p,
  output logic out_p_oe,
  output logic out_n,
  output logic out_n_oe,
  // Analog driver settings.
  output drv_type_t drv_kind,
  output logic [4:0] itail_ma,
  output logic [7:0] rload_ohm,
  output logic rload_open
);

  generate
    if (DIV_W != 8)
    begin : g_bad
      $error("output_channel_source_divider: divider is 8 bits");
    end
  endgenerate

  // Registers.
  logic [7:0] channel_four_output_control;
  logic [7:0] channel_four_output_divider;
  logic [7:0] chan_config;
  logic [7:0] chan_status;

  // Bus handshake.
  bus_state_t bus_state;
  bus_state_t next_bus_state;
  logic req;
  logic take;
  logic [5:0] idx;
  logic wr_lane;

  // Fields.
  src_sel_t chan_source_select;
  drv_type_t drv_select;
  logic [1:0] driver_setting_primary;
  logic [1:0] driver_setting_secondary;
  logic dbl_en;
  logic use_second_synth_source;

  // Clock path.
  logic ref_level;
  logic ref_q;
  logic ref_doubled;
  logic ref_path;
  logic pll_path;
  logic div_bypass;
  logic src_level;
  logic div_level;
  logic next_chan_clk;

  // Driver decode results.
  drv_cfg_t next_cfg;
  drv_pins_t next_pins;

  // Register index of a byte address.
  function automatic logic [5:0] reg_index(input logic [`ADDR_W-1:0] a);
    reg_index = a[`ADDR_W-1:2];
  endfunction

  // Read mux for one index; unmapped indices read as zero.
  function automatic logic [7:0] reg_read(input logic [5:0] i,
    input logic [7:0] c, input logic [7:0] d, input logic [7:0] f,
    input logic [7:0] s);
    case (i)
      `IDX_CTRL: reg_read = c;
      `IDX_DIV: reg_read = d;
      `IDX_CFG: reg_read = f;
      `IDX_STAT: reg_read = s;
      default: reg_read = 8'h00;
    endcase
  endfunction

  assign req = read || write;
  assign idx = reg_index(address);
  assign wr_lane = write && byteenable[0];
  // A request is taken at the edge where waitrequest is low.
  assign take = req && (bus_state == BUS_ACK);

  // One wait state: waitrequest drops in the second request cycle.
  assign waitrequest = req && (bus_state == BUS_IDLE);

  // Handshake state.
  always_comb
  begin
    case (bus_state)
      BUS_IDLE: next_bus_state = req ? BUS_ACK : BUS_IDLE;
      BUS_ACK: next_bus_state = BUS_IDLE;
      default: next_bus_state = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      bus_state <= BUS_IDLE;
    else
      bus_state <= next_bus_state;
  end

  // Read data is loaded during the wait cycle so it is stable when taken.
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      readdata <= '0;
    else if (read && bus_state == BUS_IDLE)
      readdata <= {24'h000000, reg_read(idx,
        channel_four_output_control, channel_four_output_divider,
        chan_config, chan_status)};
  end

  // Control register: source, driver type and both modes.
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      channel_four_output_control <= `RST_CTRL;
    else if (take && wr_lane && idx == `IDX_CTRL)
      channel_four_output_control <= writedata[7:0];
  end

  // Divider register; a new ratio applies from the next source edge.
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      channel_four_output_divider <= `RST_DIV;
    else if (take && wr_lane && idx == `IDX_DIV)
      channel_four_output_divider <= writedata[7:0];
  end

  // Configuration register: doubler enable and second synth source.
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      chan_config <= `RST_CFG;
    else if (take && wr_lane && idx == `IDX_CFG)
      chan_config <= {6'h00, writedata[1:0]};
  end

  // Field split.
  assign chan_source_select =
    src_sel_t'(channel_four_output_control[`F_MUX +: 2]);
  assign drv_select = drv_type_t'(channel_four_output_control[`F_SEL +: 2]);
  assign driver_setting_primary =
    channel_four_output_control[`F_MODE1 +: 2];
  assign driver_setting_secondary =
    channel_four_output_control[`F_MODE2 +: 2];
  assign dbl_en = chan_config[`CFG_DBL];
  assign use_second_synth_source = chan_config[`CFG_SECOND_SYNTH];

  // Reference picked by the mux; secondary unless primary is chosen.
  assign ref_level = (chan_source_select == SRC_PRI) ? pri_ref_in :
    sec_ref_in;

  // doubler pulses once per reference edge, twice per period.
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      ref_q <= 1'b0;
      ref_doubled <= 1'b0;
    end
    else
    begin
      ref_q <= ref_level;
      ref_doubled <= ref_level ^ ref_q;
    end
  end

  // doubled reference replaces the raw one when enabled.
  assign ref_path = dbl_en ? ref_doubled : ref_level;
  assign pll_path = use_second_synth_source ? second_synth_source_in :
    pll_clk_in;

  // source mux; the reserved code gives no clock at all.
  always_comb
  begin
    case (chan_source_select)
      SRC_PLL: src_level = pll_path;
      SRC_PRI: src_level = ref_path;
      SRC_SEC: src_level = ref_path;
      default: src_level = 1'b0;
    endcase
  end

  assign div_bypass = (chan_source_select != SRC_PLL);

  // ratio is the divider field plus one.
  ratio_divider #(
    .DIV_W(DIV_W)
  ) u_div (
    .clock(clock),
    .rst_b(rst_b),
    .bypass(div_bypass),
    .ratio_code(channel_four_output_divider[DIV_W-1:0]),
    .src_level(src_level),
    .div_out(div_level)
  );

  // A disabled driver holds the channel clock low to save switching.
  assign next_chan_clk = (drv_select == DRV_OFF) ? 1'b0 : div_level;

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      chan_clk <= 1'b0;
    else
      chan_clk <= next_chan_clk;
  end

  driver_decode u_drv (
    .kind(drv_select),
    .mode_primary(driver_setting_primary),
    .mode_secondary(driver_setting_secondary),
    .clk_level(next_chan_clk),
    .cfg(next_cfg),
    .pins(next_pins)
  );

  // driver settings registered toward the analog stage.
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      drv_kind <= DRV_OFF;
      itail_ma <= 5'h00;
      rload_ohm <= 8'h00;
      rload_open <= 1'b1;
    end
    else
    begin
      drv_kind <= next_cfg.kind;
      itail_ma <= next_cfg.itail_ma;
      rload_ohm <= next_cfg.rload_ohm;
      rload_open <= next_cfg.rload_open;
    end
  end

  // leg levels and enables registered, all released in reset.
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      out_p <= 1'b0;
      out_p_oe <= 1'b0;
      out_n <= 1'b0;
      out_n_oe <= 1'b0;
    end
    else
    begin
      out_p <= next_pins.p;
      out_p_oe <= next_pins.p_oe;
      out_n <= next_pins.n;
      out_n_oe <= next_pins.n_oe;
    end
  end

  // Status mirrors the live path, one cycle behind the fields.
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      chan_status <= 8'h00;
    else
    begin
      chan_status <= 8'h00;
      chan_status[1:0] <= chan_source_select;
      chan_status[`ST_DIV_ON] <= !div_bypass;
      chan_status[`ST_OUT_ON] <= (drv_select != DRV_OFF);
      chan_status[`ST_CLK] <= next_chan_clk;
      chan_status[`ST_RSVD] <= (chan_source_select == SRC_RSVD);
    end
  end

endmodule

/* verification/outchan_sva.sv */
/*
  Checker for the channel four source and divider block.
  Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/1ps

module outchan_sva
  import outchan_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Bus handshake.
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Driver outputs.
  input wire logic out_p,
  input wire logic out_p_oe,
  input wire logic out_n,
  input wire logic out_n_oe,
  input wire drv_type_t drv_kind,
  input wire logic [4:0] itail_ma,
  input wire logic [7:0] rload_ohm,
  input wire logic rload_open
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  // Every request, back to back ones too, sees exactly one wait state.
  a_wait_start: assert property ($rose(read || write) |-> waitrequest)
    else $error("request started without a wait state");
  a_wait_again: assert property ((read || write) && !waitrequest ##1
    (read || write) |-> waitrequest)
    else $error("back to back request without a wait state");
  a_wait_end: assert property ((read || write) && waitrequest |=>
    !waitrequest)
    else $error("wait state longer than one cycle");
  a_rdata_hold: assert property (!(read && waitrequest) |=>
    $stable(readdata) && readdata[31:8] == 24'h000000)
    else $error("read data moved outside a read");
  a_off_tristate: assert property (
    drv_kind == DRV_OFF |-> !out_p_oe && !out_n_oe)
    else $error("disabled driver drives a leg");
  a_diff_legs: assert property (
    drv_kind inside {DRV_AC, DRV_HCSL} |-> out_p_oe && out_n_oe &&
    out_n != out_p)
    else $error("differential legs not complementary");
  a_ac_tail: assert property (
    drv_kind == DRV_AC |-> itail_ma inside {5'h04, 5'h06, 5'h08})
    else $error("bad tail current for AC driver");
  a_hcsl_tail: assert property (
    drv_kind == DRV_HCSL |-> itail_ma inside {5'h04, 5'h06, 5'h08, 5'h10})
    else $error("bad tail current for HCSL driver");
  a_se_no_tail: assert property (
    drv_kind inside {DRV_OFF, DRV_CMOS} |-> itail_ma == 5'h00)
    else $error("tail current outside differential use");
  a_load_value: assert property (
    rload_ohm != 8'h00 |-> !rload_open && drv_kind == DRV_HCSL &&
    rload_ohm inside {8'h32, 8'h64, 8'hC8})
    else $error("load value outside HCSL use");

  // Main scenarios.
  c_write: cover property (write && !waitrequest);
  c_read: cover property (read && !waitrequest);
  c_hcsl: cover property (drv_kind == DRV_HCSL && rload_ohm == 8'hC8);
  c_cmos: cover property (drv_kind == DRV_CMOS && out_p_oe);
endmodule

/* verification/testbench.sv */
/*
  Self-checking bench: register access, driver decode table, source mux
  and divider periods measured on the channel clock.
  Assumes the package and the design files are compiled first.
*/
`timescale 1ns/1ps

module testbench
  import outchan_pkg::*;
;
  localparam logic [7:0] A_CTRL = 8'h94;
  localparam logic [7:0] A_DIV = 8'h98;
  localparam logic [7:0] A_CFG = 8'h9C;
  localparam logic [7:0] A_STAT = 8'hA0;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic [3:0] src = 4'h0;
  logic [31:0] readdata, q0;
  logic waitrequest, chan_clk, out_p, out_p_oe, out_n, out_n_oe, rload_open;
  drv_type_t drv_kind;
  logic [4:0] itail_ma;
  logic [7:0] rload_ohm;
  int scnt[4] = '{0, 0, 0, 0};
  int error_cnt = 0;
  int comparisons = 0;

  // Free-running clock at 50 MHz.
  initial
  begin
    forever #10 clock = ~clock;
  end

  // Source levels with half periods of 4, 5, 6 and 7 cycles.
  always @(posedge clock)
  begin
    for (int k = 0; k < 4; k++)
    begin
      scnt[k] <= (scnt[k] == k + 3) ? 0 : scnt[k] + 1;
      if (scnt[k] == k + 3)
        src[k] <= ~src[k];
    end
  end

  output_channel_source_divider output_channel_source_divider_i (
    .clock, .rst_b, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .pll_clk_in(src[0]),
    .second_synth_source_in(src[1]),
    .pri_ref_in(src[2]), .sec_ref_in(src[3]), .chan_clk, .out_p,
    .out_p_oe, .out_n, .out_n_oe, .drv_kind, .itail_ma, .rload_ohm,
    .rload_open);

  task automatic check(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic fail_wait();
    error_cnt++;
    $display("MISMATCH wait expected done seen timeout");
    end_of_test();
  endtask

  // Holds the request until waitrequest is sampled low; no release here,
  // so two calls in a row make back to back transfers.
  task automatic bus(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= d;
    @(posedge clock);
    while (waitrequest !== 1'b0)
    begin
      n++;
      if (n > 50)
        fail_wait();
      @(posedge clock);
    end
    q = readdata;
  endtask

  task automatic rel();
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d}, q0);
    rel();
  endtask

  task automatic rchk(input string nm, input logic [7:0] a,
    input logic [31:0] exp);
    bus(1'b0, a, 32'h0, q0);
    rel();
    check(nm, q0, exp);
  endtask

  // Cycles between two clean rising edges of the channel clock.
  task automatic period(output int p);
    int n;
    logic prev;
    for (int r = 0; r < 3; r++)
    begin
      n = 0;
      prev = 1'b1;
      while (!(chan_clk === 1'b1 && prev === 1'b0))
      begin
        prev = chan_clk;
        @(posedge clock);
        n++;
        if (n > 5000)
          fail_wait();
      end
      p = n;
    end
  endtask

  // Expected driver vector with the channel clock stopped low.
  function automatic logic [19:0] dexp(input int s, input int m1,
    input int m2);
    logic [4:0] it;
    logic [7:0] rl;
    logic [3:0] lg;
    it = 5'h00;
    rl = 8'h00;
    lg = 4'h0;
    if (s == 1 || s == 2)
    begin
      it = (m1 == 0) ? 5'h04 : (m1 == 1) ? 5'h06 :
        (m1 == 3 && s == 2) ? 5'h10 : 5'h08;
      lg = 4'h7;
    end
    if (s == 2 && m2 != 0)
      rl = 8'h19 << m2;
    if (s == 3)
      lg = {m1 == 2, m1 != 0, m2 == 2, m2 != 0};
    return {s[1:0], it, rl, rl == 8'h00, lg};
  endfunction

  logic [7:0] tcfg[10] = '{0, 0, 0, 0, 2, 0, 0, 1, 1, 1};
  logic [1:0] tmux[10] = '{0, 0, 0, 0, 0, 2, 3, 2, 3, 0};
  logic [7:0] tdiv[10] = '{0, 1, 2, 255, 2, 4, 4, 4, 4, 0};
  int tper[10] = '{8, 16, 24, 2048, 30, 12, 14, 6, 7, 8};

  // Main sequence.
  initial
  begin
    logic [19:0] e;
    logic [19:0] m;
    logic [19:0] g;
    int p;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rchk("ctrl reset", A_CTRL, 32'h18);
    rchk("div reset", A_DIV, 32'h02);
    rchk("cfg reset", A_CFG, 32'h00);
    check("kind reset", drv_kind, DRV_AC);
    check("tail reset", itail_ma, 5'h08);
    bus(1'b1, A_DIV, 32'hA5, q0);
    bus(1'b0, A_DIV, 32'h0, q0);
    rel();
    check("div back to back", q0, 32'hA5);
    byteenable <= 4'hE;
    wr(A_DIV, 8'h5A);
    byteenable <= 4'hF;
    rchk("div lane off", A_DIV, 32'hA5);
    wr(8'hFC, 8'hFF);
    rchk("unmapped", 8'hFC, 32'h0);
    wr(A_DIV, 8'h00);
    wr(A_CTRL, 8'h58);
    wr(A_STAT, 8'hFF);
    bus(1'b0, A_STAT, 32'h0, q0);
    rel();
    check("status reserved", q0 & 32'h3F, 32'h29);
    $display("Test registers done");
    repeat (20) @(posedge clock);
    check("reserved clock", chan_clk, 1'b0);
    for (int s = 0; s < 4; s++)
      for (int m1 = 0; m1 < 4; m1++)
        for (int m2 = 0; m2 < 4; m2++)
        begin
          wr(A_CTRL, {2'h1, s[1:0], m1[1:0], m2[1:0]});
          repeat (4) @(posedge clock);
          e = dexp(s, m1, m2);
          m = {16'hFFFF, e[2], 1'b1, e[0], 1'b1};
          g = {drv_kind, itail_ma, rload_ohm, rload_open, out_p, out_p_oe,
            out_n, out_n_oe};
          check("driver", g & m, e & m);
        end
    $display("Test driver decode done");
    for (int t = 0; t < 10; t++)
    begin
      wr(A_CFG, tcfg[t]);
      wr(A_DIV, tdiv[t]);
      wr(A_CTRL, {tmux[t], 6'h18});
      period(p);
      check("period", p, tper[t]);
      // Divider is reported active only for the synthesizer sources.
      bus(1'b0, A_STAT, 32'h0, q0);
      rel();
      check("div on", q0[3:0], {1'b1, tmux[t] == 0, tmux[t]});
    end
    $display("Test source and divider done");
    end_of_test();
  end
endmodule

bind output_channel_source_divider outchan_sva outchan_sva_i (
  .clock, .rst_b, .read, .write, .readdata, .waitrequest, .out_p,
  .out_p_oe, .out_n, .out_n_oe, .drv_kind, .itail_ma, .rload_ohm,
  .rload_open);
